// ==== design/rcb_pkg.sv ====
// Constants, register map and carrier types for the reference clock buffer.
// Assumes a 32-bit APB master and a single 250 MHz system clock.
package rcb_pkg;
    localparam int unsigned MCLK_MHZ = 250;
    localparam int unsigned ADDR_W = 12;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned NUM_CH = 4;
    localparam int unsigned CH_W = 2;
    localparam int unsigned SYNC_STAGES = 2;

    // Register byte addresses
    localparam logic [ADDR_W-1:0] CTRL_OFFSET = 12'h000;
    localparam logic [ADDR_W-1:0] STATUS_OFFSET = 12'h004;

    // Control field positions
    localparam int unsigned CTRL_MODE_BIT = 0;
    localparam int unsigned CTRL_DIR_BIT = 1;
    localparam int unsigned CTRL_AUX_LSB = 2;
    localparam int unsigned CTRL_RUNTIME_BIT = 4;
    localparam int unsigned CTRL_FIXED_LSB = 5;
    localparam int unsigned CTRL_W = 7;

    // Status field positions
    localparam int unsigned STAT_ENABLED_BIT = 0;
    localparam int unsigned STAT_MAIN_BIT = 1;
    localparam int unsigned STAT_AUX_BIT = 2;
    localparam int unsigned STAT_OE_BIT = 3;
    localparam int unsigned STAT_CFGERR_BIT = 4;
    localparam int unsigned STAT_CH_LSB = 5;

    // Auxiliary output source codes
    localparam logic [1:0] AUX_PASS = 2'h0;
    localparam logic [1:0] AUX_DIV2 = 2'h1;
    localparam logic [1:0] AUX_LOW = 2'h2;
    localparam logic [1:0] AUX_RSVD = 2'h3;

    localparam logic MODE_INPUT = 1'h0;
    localparam logic MODE_OUTPUT = 1'h1;

    typedef struct packed {
        logic [CH_W-1:0] fixed_channel;
        logic runtime_select;
        logic [1:0] aux_clock_source_select;
        logic drive_direction_enable;
        logic mode;
    } rcb_cfg_type;

    localparam rcb_cfg_type CFG_RESET = '{
        fixed_channel: 2'h0,
        runtime_select: 1'h0,
        aux_clock_source_select: AUX_PASS,
        drive_direction_enable: 1'h0,
        mode: MODE_INPUT
    };

    typedef struct packed {
        logic p;
        logic n;
    } rcb_diff_type;
endpackage : rcb_pkg

// ==== design/rcb_refclk_buffer.sv ====
// Reference clock input/output buffer of a transceiver quad, sampled on mclk.
// Assumes pad and recovered clocks are well below mclk/2 and an APB master.
// Functional notes
// (R1) Enable low active; high powers down outputs
// (R2) Aux output: pass, divide by two, low
// (R3) Input mode needs drive enable cleared
// (R4) Output mode needs drive enable set
// (R5) Mode fixed while buffer is running
// (R6) Output mode routes one recovered clock
// (R7) Runtime channel change needs selectable variant
// (R8) Input mode main clock feeds local PLLs
// (R9) Two-bit select picks channel zero to three
// (R10) Divider toggles on rise, starts low
//
// Register access over APB and the placing of the registers are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none

module rcb_sync #(
    parameter int unsigned WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_q;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= RESET_VALUE;
            sync_out <= RESET_VALUE;
        end else begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule : rcb_sync

module rcb_refclk_buffer (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [rcb_pkg::ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [rcb_pkg::DATA_W-1:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic pready,
    output logic [rcb_pkg::DATA_W-1:0] prdata,
    output logic pslverr,
    input wire logic buffer_enable_n,
    input wire rcb_pkg::rcb_diff_type pad_in,
    output rcb_pkg::rcb_diff_type pad_out,
    output logic pad_oe,
    input wire logic [rcb_pkg::NUM_CH-1:0] recovered_rx_clock,
    input wire logic [rcb_pkg::CH_W-1:0] recovered_channel_select,
    output logic local_ref_clock_zero,
    output logic aux_fabric_clock_out
);
    rcb_pkg::rcb_cfg_type cfg_q;
    rcb_pkg::rcb_diff_type pad_s;
    logic en_n_s;
    logic [rcb_pkg::NUM_CH-1:0] rec_s;
    logic [rcb_pkg::CH_W-1:0] sel_s;
    logic ref_s;
    logic ref_prev_q;
    logic ref_rise;
    logic enabled;
    logic in_active;
    logic out_active;
    logic div_q;
    logic main_q;
    logic aux_q;
    logic aux_d;
    logic [rcb_pkg::CH_W-1:0] ch_d;
    logic [rcb_pkg::CH_W-1:0] ch_q;
    logic cfg_err;
    logic acc;
    logic hit_ctrl;
    logic hit_stat;

    // Every pin input crosses two flops before use
    // (R1) Enable sync resets to powered down, no start glitch
    rcb_sync #(.WIDTH(1), .RESET_VALUE(1'b1)) u_sync_en (
        .mclk(mclk), .rst_n(rst_n), .async_in(buffer_enable_n), .sync_out(en_n_s));
    rcb_sync #(.WIDTH(2)) u_sync_pad (
        .mclk(mclk), .rst_n(rst_n), .async_in(pad_in), .sync_out(pad_s));
    rcb_sync #(.WIDTH(rcb_pkg::NUM_CH)) u_sync_rec (
        .mclk(mclk), .rst_n(rst_n), .async_in(recovered_rx_clock), .sync_out(rec_s));
    rcb_sync #(.WIDTH(rcb_pkg::CH_W)) u_sync_sel (
        .mclk(mclk), .rst_n(rst_n), .async_in(recovered_channel_select), .sync_out(sel_s));

    // Differential level: high only when legs disagree the right way
    assign ref_s = pad_s.p & ~pad_s.n;
    assign ref_rise = ref_s & ~ref_prev_q;
    // (R1) Enable is active low
    assign enabled = ~en_n_s;
    assign in_active = enabled & (cfg_q.mode == rcb_pkg::MODE_INPUT);
    assign out_active = enabled & (cfg_q.mode == rcb_pkg::MODE_OUTPUT);
    // (R3) (R4) Flag a direction enable that contradicts the mode
    assign cfg_err = cfg_q.drive_direction_enable != cfg_q.mode;

    // APB slave, zero wait states
    assign pready = 1'b1;
    assign acc = psel & penable;
    assign hit_ctrl = paddr == rcb_pkg::CTRL_OFFSET;
    assign hit_stat = paddr == rcb_pkg::STATUS_OFFSET;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_q <= rcb_pkg::CFG_RESET;
        end else if (acc && pwrite && hit_ctrl && pstrb[0]) begin
            cfg_q.drive_direction_enable <= pwdata[rcb_pkg::CTRL_DIR_BIT];
            cfg_q.aux_clock_source_select <= pwdata[rcb_pkg::CTRL_AUX_LSB +: 2];
            cfg_q.runtime_select <= pwdata[rcb_pkg::CTRL_RUNTIME_BIT];
            cfg_q.fixed_channel <= pwdata[rcb_pkg::CTRL_FIXED_LSB +: rcb_pkg::CH_W];
            // (R5) Mode only changes while powered down
            if (!enabled) begin
                cfg_q.mode <= pwdata[rcb_pkg::CTRL_MODE_BIT];
            end
        end
    end

    always_comb begin
        prdata = '0;
        pslverr = 1'b0;
        if (acc) begin
            if (hit_ctrl) begin
                prdata[rcb_pkg::CTRL_W-1:0] = cfg_q;
            end else if (hit_stat) begin
                prdata[rcb_pkg::STAT_ENABLED_BIT] = enabled;
                prdata[rcb_pkg::STAT_MAIN_BIT] = main_q;
                prdata[rcb_pkg::STAT_AUX_BIT] = aux_q;
                prdata[rcb_pkg::STAT_OE_BIT] = pad_oe;
                prdata[rcb_pkg::STAT_CFGERR_BIT] = cfg_err;
                prdata[rcb_pkg::STAT_CH_LSB +: rcb_pkg::CH_W] = ch_q;
            end else begin
                pslverr = 1'b1;
            end
        end
    end

    // Input path
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ref_prev_q <= 1'b0;
        end else begin
            ref_prev_q <= ref_s;
        end
    end

    // (R10) Divider cleared while off, toggles per rise
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            div_q <= 1'b0;
        end else if (!in_active) begin
            div_q <= 1'b0;
        end else if (ref_rise) begin
            div_q <= ~div_q;
        end
    end

    // (R2) Aux source select
    always_comb begin
        aux_d = 1'b0;
        if (in_active) begin
            unique case (cfg_q.aux_clock_source_select)
                rcb_pkg::AUX_PASS: aux_d = ref_s;
                rcb_pkg::AUX_DIV2: aux_d = div_q ^ ref_rise;
                rcb_pkg::AUX_LOW: aux_d = 1'b0;
                rcb_pkg::AUX_RSVD: aux_d = 1'b0;
            endcase
        end
    end

    // (R8) (R1) Main clock to local PLL inputs, quiet when off
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            main_q <= 1'b0;
            aux_q <= 1'b0;
        end else begin
            main_q <= in_active & ref_s;
            aux_q <= aux_d;
        end
    end
    assign local_ref_clock_zero = main_q;
    assign aux_fabric_clock_out = aux_q;

    // (R9) (R7) Runtime select or fixed channel
    assign ch_d = cfg_q.runtime_select ? sel_s : cfg_q.fixed_channel;

    // (R6) (R1) Drive chosen recovered clock onto pads
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pad_out <= '0;
            pad_oe <= 1'b0;
            ch_q <= '0;
        end else begin
            ch_q <= ch_d;
            pad_oe <= out_active;
            pad_out.p <= out_active & rec_s[ch_d];
            pad_out.n <= out_active & ~rec_s[ch_d];
        end
    end

    AST_DISABLE_QUIET: assert property (@(posedge mclk) disable iff (!rst_n) // (R1)
        en_n_s |=> !main_q && !aux_q && !pad_oe && !pad_out.p && !pad_out.n)
        else $error("outputs active while disabled");
    AST_AUX_PASS: assert property (@(posedge mclk) disable iff (!rst_n) // (R2)
        in_active && cfg_q.aux_clock_source_select == rcb_pkg::AUX_PASS
        |=> aux_q == main_q)
        else $error("aux pass differs from main");
    AST_AUX_LOW: assert property (@(posedge mclk) disable iff (!rst_n) // (R2)
        cfg_q.aux_clock_source_select[1] |=> !aux_q)
        else $error("aux not held low");
    AST_AUX_DIV: assert property (@(posedge mclk) disable iff (!rst_n) // (R2)
        in_active && cfg_q.aux_clock_source_select == rcb_pkg::AUX_DIV2
        |=> aux_q == div_q)
        else $error("aux not divided clock");
    AST_DIV_TOGGLE: assert property (@(posedge mclk) disable iff (!rst_n) // (R10)
        in_active && ref_rise |=> div_q != $past(div_q))
        else $error("divider missed a rise");
    AST_DIV_HOLD: assert property (@(posedge mclk) disable iff (!rst_n) // (R10)
        in_active && !ref_rise |=> $stable(div_q) || !in_active)
        else $error("divider moved without rise");
    AST_DIV_START_LOW: assert property (@(posedge mclk) disable iff (!rst_n) // (R10)
        $rose(in_active) |-> !div_q)
        else $error("divider not low at start");
    AST_MAIN_FOLLOW: assert property (@(posedge mclk) disable iff (!rst_n) // (R8)
        in_active |=> main_q == $past(ref_s))
        else $error("main clock does not follow pad");
    AST_OUT_ROUTE: assert property (@(posedge mclk) disable iff (!rst_n) // (R6)
        out_active |=> pad_oe && pad_out.p == $past(rec_s[ch_d]) && pad_out.n != pad_out.p)
        else $error("recovered clock not routed");
    AST_RUNTIME_SEL: assert property (@(posedge mclk) disable iff (!rst_n) // (R9)
        out_active && cfg_q.runtime_select |=> ch_q == $past(sel_s))
        else $error("runtime select ignored");
    AST_MODE_LOCKED: assert property (@(posedge mclk) disable iff (!rst_n) // (R5)
        enabled |=> cfg_q.mode == $past(cfg_q.mode))
        else $error("mode changed while running");
    AST_INPUT_NO_DRIVE: assert property (@(posedge mclk) disable iff (!rst_n) // (R3)
        cfg_q.mode == rcb_pkg::MODE_INPUT |=> !pad_oe)
        else $error("pads driven in input mode");

    COV_DIV_RUN: cover property (@(posedge mclk) disable iff (!rst_n)
        in_active && cfg_q.aux_clock_source_select == rcb_pkg::AUX_DIV2 && ref_rise);
    COV_OUT_CH3: cover property (@(posedge mclk) disable iff (!rst_n)
        out_active && ch_d == 2'h3);
    COV_SEL_SWITCH: cover property (@(posedge mclk) disable iff (!rst_n)
        out_active && cfg_q.runtime_select && $changed(sel_s));
    COV_UNMAPPED: cover property (@(posedge mclk) disable iff (!rst_n) pslverr);
endmodule : rcb_refclk_buffer

`default_nettype wire

// ==== test/rcb_clk_source.sv ====
// Reference oscillator and four recovered channel clocks for the buffer bench.
// Assumes every clock stays far below mclk/2 so the synchronisers see each level.
`timescale 1ns/10ps
`default_nettype none
module rcb_clk_source (
    input wire logic mclk,
    output rcb_pkg::rcb_diff_type pad,
    output logic [3:0] rec
);
    logic [7:0] cnt = 8'h00;
    // Oscillator runs free, so it keeps toggling with the buffer powered down
    always @(posedge mclk) begin
        cnt <= cnt + 8'h01;
    end
    // Differential pair is always complementary
    assign pad = '{p: cnt[2], n: !cnt[2]};
    // Each channel has its own rate so a wrong route shows up
    assign rec = cnt[5:2];
endmodule : rcb_clk_source
`default_nettype wire

// ==== test/rcb_refclk_buffer_bench.sv ====
// Self-checking bench for the reference clock buffer with a cycle model.
// Assumes the clock source model of rcb_clk_source and APB with zero wait.
`timescale 1ns/10ps
`default_nettype none
module rcb_refclk_buffer_bench;
    logic mclk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, ben_n = 1;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, rd, prdata;
    logic [3:0] pstrb = 4'hf, rec;
    logic [1:0] sel = 2'h0, ref_s, en_s, sel_s1, sel_s2;
    logic pready, pslverr, pad_oe, main_o, aux_o, er, m_main, m_aux, m_div, m_oe, m_p, pm, pa;
    logic m_dv, m_rp;
    logic [3:0] rec_s1, rec_s2;
    logic [6:0] ctrl;
    logic [7:0] lfsr = 8'h57;
    rcb_pkg::rcb_diff_type pad_in, pad_out;
    int error_cnt = 0, checks = 0, cyc = 0, quiet = 0, nr = 0, na = 0;
    always #2 mclk = !mclk;
    rcb_clk_source rcb_clk_source_i (.mclk(mclk), .pad(pad_in), .rec(rec));
    rcb_refclk_buffer rcb_refclk_buffer_i (.mclk(mclk), .rst_n(rst_n), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
        .pready(pready), .prdata(prdata), .pslverr(pslverr), .buffer_enable_n(ben_n),
        .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe), .recovered_rx_clock(rec),
        .recovered_channel_select(sel), .local_ref_clock_zero(main_o),
        .aux_fabric_clock_out(aux_o));
    function automatic logic [7:0] lfsr_next(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction : lfsr_next
    task automatic print_verdict;
        if (error_cnt == 0 && checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : print_verdict
    task automatic chk(input logic got, input logic exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t bit got %b exp %b", $time, got, exp);
        end
    endtask : chk
    task automatic chkw(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t word got %h exp %h", $time, got, exp);
        end
    endtask : chkw
    // Called just after a rising edge; holds the request until pready
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask : apb
    // Model: two sync stages, then the output flops, mode locked while enabled
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            {en_s, ref_s, sel_s1, sel_s2, rec_s1, rec_s2, ctrl} = '0;
            {m_main, m_aux, m_div, m_oe, m_p, m_dv, m_rp} = '0;
            quiet = 0;
        end else begin
            m_main = en_s[1] & !ctrl[0] & ref_s[1];
            // Divider starts low while off and toggles on each synced rise
            m_dv = (en_s[1] & !ctrl[0]) ? m_dv ^ (ref_s[1] & !m_rp) : 1'b0;
            m_rp = ref_s[1];
            m_div = ctrl[3:2] == 2'h1;
            m_aux = m_div ? m_dv : (ctrl[3:2] == 2'h0) & m_main;
            m_oe = en_s[1] & ctrl[0];
            m_p = m_oe & rec_s2[ctrl[4] ? sel_s2 : ctrl[6:5]];
            if (psel && penable && pwrite && pstrb[0] && paddr == 12'h000)
                ctrl = en_s[1] ? {pwdata[6:1], ctrl[0]} : pwdata[6:0];
            en_s = {en_s[0], !ben_n};
            ref_s = {ref_s[0], pad_in.p & !pad_in.n};
            sel_s2 = sel_s1;
            sel_s1 = sel;
            rec_s2 = rec_s1;
            rec_s1 = rec;
            quiet++;
        end
    end
    always @(negedge mclk) if (rst_n && quiet > 0) begin
        chk(main_o, m_main);
        chk(aux_o, m_aux);
        chk(pad_oe, m_oe);
        chk(pad_out.p, m_p);
        chk(pad_out.n, m_oe & !m_p);
        nr += int'(m_div & main_o & !pm);
        na += int'(m_div & aux_o & !pa);
        pm = main_o;
        pa = aux_o;
    end
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 5000) begin
            error_cnt++;
            print_verdict();
        end
    end
    initial begin
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (6) @(posedge mclk);
        apb(1'b0, 12'h000, 32'h0);
        chkw(rd, 32'h0);
        apb(1'b0, 12'h008, 32'h0);
        chkw({rd[31:1], er}, 32'h1);
        apb(1'b1, 12'h004, 32'h7f);
        apb(1'b0, 12'h000, 32'h0);
        chkw(rd, 32'h0);
        ben_n <= 1'b0;
        // Direction bit stays clear in input mode
        for (int c = 0; c < 4; c++) begin
            apb(1'b1, 12'h000, 32'(c) << 2);
            nr = 0;
            na = 0;
            repeat (60) @(posedge mclk);
            if (c == 1) chk((2 * na - nr) inside {[-2:2]}, 1'b1);
        end
        apb(1'b1, 12'h000, 32'h1);
        apb(1'b0, 12'h000, 32'h0);
        chkw(rd, 32'h0);
        apb(1'b0, 12'h004, 32'h0);
        chkw(rd & 32'h79, 32'h1);
        ben_n <= 1'b1;
        repeat (8) @(posedge mclk);
        apb(1'b1, 12'h000, 32'h1);
        apb(1'b0, 12'h004, 32'h0);
        chkw(rd & 32'h79, 32'h10);
        // Direction bit set in output mode
        for (int ch = 0; ch < 4; ch++) begin
            apb(1'b1, 12'h000, 32'h3 | (32'(ch) << 5));
            ben_n <= 1'b0;
            repeat (70) @(posedge mclk);
        end
        apb(1'b0, 12'h004, 32'h0);
        chkw(rd & 32'h79, 32'h69);
        apb(1'b1, 12'h000, 32'h13);
        for (int i = 0; i < 30; i++) begin
            lfsr = lfsr_next(lfsr);
            sel <= lfsr[1:0];
            repeat (12) @(posedge mclk);
        end
        // Reset mid-run: control back to input mode, enable sync starts off
        rst_n <= 1'b0;
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
        apb(1'b0, 12'h000, 32'h0);
        chkw(rd, 32'h0);
        apb(1'b0, 12'h004, 32'h0);
        chkw(rd & 32'h79, 32'h1);
        ben_n <= 1'b1;
        repeat (10) @(posedge mclk);
        print_verdict();
    end
endmodule : rcb_refclk_buffer_bench
`default_nettype wire
